// ### verilog/power_reset_regs.svh
// offsets, field positions, reset values and timing counts of the power/reset sequencer
`ifndef POWER_RESET_REGS_SVH
`define POWER_RESET_REGS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define BOOT_DELAY_CONFIG_ADDR 8'h4d
`define POWER_COMMAND_ADDR 8'h4e
`define SEQ_STATUS_ADDR 8'h4f
`define BOOT_DELAY_LSB 0
`define BOOT_DELAY_MSB 1
`define BOOT_DELAY_RESET 2'h0
`define POWER_OFF_BIT 0

// ----------------------------------------
// timebase
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define MS_PER_S 14'd1000

// ----------------------------------------
// delays in milliseconds or seconds
// ----------------------------------------
`define DEBOUNCE_MS 14'd10
`define SHORT_DELAY_MS 14'd200
`define KEY_SHORT_MS 14'd400
`define KEY_LONG_S 14'd3
`define KEY_OFF_S 14'd12
`define ABORT_DELAY_S 14'd15
`define SYS_PATH_MS 14'd30
`define SEQ_START_MS 14'd45
`define SOFT_PULSE_MS 14'd10
`define OC_DEGLITCH_MS 14'd16
`define BOOT_DLY0_MS 14'd80
`define BOOT_DLY1_MS 14'd180
`define BOOT_DLY2_MS 14'd300
`define BOOT_DLY3_MS 14'd420
`define BLANK1_MS 14'd5
`define BLANK2_MS 14'd10
`define BLANK3_MS 14'd20

// ----------------------------------------
// regulator set
// ----------------------------------------
`define REG_COUNT 9
`define LDO1_IDX 3
`define SEQ_DEFAULT_OFF 3'h4
`define ILIM_MAX 3'h7

`endif

// ### verilog/power_reset_pkg.sv
// types shared by the power/reset sequencer
package power_reset_pkg;
	typedef logic [13:0] ms_t;
	typedef logic [2:0] seq_sel_t;

	typedef enum logic [1:0] {
		ST_OFF = 2'h0,
		ST_SEQ = 2'h1,
		ST_ON = 2'h3
	} pwr_state_t;

	typedef enum logic [3:0] {
		MODE_ONOFF_HI = 4'h0,
		MODE_ONOFF_LO = 4'h1,
		MODE_EDGE_RISE = 4'h2,
		MODE_EDGE_FALL = 4'h3,
		MODE_INS_HI = 4'h4,
		MODE_INS_LO = 4'h5,
		MODE_KEY_ONOFF = 4'h6,
		MODE_KEY_RESET = 4'h7,
		MODE_KEY_MANUAL = 4'h8,
		MODE_ABORT_HI = 4'h9,
		MODE_ABORT_LO = 4'ha
	} mode_t;

	typedef struct packed {
		logic chg_det;
		logic chg_above_cell;
		logic chg_ov;
		logic sys_uvlo;
		logic cell_oc;
		logic supply_present;
	} supply_t;

	typedef struct packed {
		logic active;
		logic hard;
		logic pin_b;
		logic abort_en;
		logic abort_lvl;
		ms_t ms;
	} pend_t;
endpackage : power_reset_pkg

// ### verilog/pin_filter.sv
// synchroniser, debounce and held-low timer for one control pin
`timescale 1ns/10ps
`include "power_reset_regs.svh"

module pin_filter (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_pin,
	input wire logic i_ms_tick,
	output logic o_level,
	output power_reset_pkg::ms_t o_low_ms
);
	logic sync1_r;
	logic sync2_r;
	power_reset_pkg::ms_t stable_ms_r;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= i_pin;
			sync2_r <= sync1_r;
		end
	end

	// level only follows after it has held for the whole debounce time
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_level <= 1'b1;
			stable_ms_r <= '0;
		end else if (sync2_r == o_level) begin
			stable_ms_r <= '0;
		end else if (i_ms_tick) begin
			if (stable_ms_r >= `DEBOUNCE_MS - 14'd1) begin
				o_level <= sync2_r;
				stable_ms_r <= '0;
			end else begin
				stable_ms_r <= stable_ms_r + 14'd1;
			end
		end
	end

	// saturates so a stuck key never wraps into a fresh threshold hit
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_low_ms <= '0;
		end else if (o_level) begin
			o_low_ms <= '0;
		end else if (i_ms_tick && o_low_ms != 14'h3fff) begin
			o_low_ms <= o_low_ms + 14'd1;
		end
	end
endmodule : pin_filter

// ### verilog/power_reset_sequencer.sv
// power function controller: pin modes, delayed resets, regulator sequencing, power path
//
// What this block does
// RL1 - mode 0000: pin a high-on, b low softreset
// RL2 - mode 0001: pin a low-on, b softreset
// RL3 - mode 0010: rising edges reset after 200ms
// RL4 - mode 0011: falling edges reset after 200ms
// RL5 - always-on modes: off only by command, overcurrent or undervoltage
// RL6 - mode 0100: high at insertion, reset 200ms
// RL7 - mode 0101: low at insertion, reset 200ms
// RL8 - mode 0110: key on 400ms, off 12s
// RL9 - mode 0111: key on 3s, softreset 12s
// RL10 - mode 1000: key on 3s, pin b softreset
// RL11 - mode 1001: high at insertion, abortable 15s reset
// RL12 - mode 1010: low at insertion, abortable 15s reset
// RL13 - regulators enable at their selected sequence point
// RL14 - reset held for selectable boot delay
// RL15 - default-off regulators wait for later command
// RL16 - always-on first ldo follows supply presence
// RL17 - rail undervoltage restarts or powers off
// RL18 - persistent cell overcurrent powers off
// RL19 - cell switch closed without valid charger
// RL20 - charger overvoltage: lockout, switch closed, interrupt
// RL21 - charger invalid below cell or threshold
// RL22 - input limit maximum during blanking time
// RL23 - soft reset gives 10ms reset pulse
// RL24 - hard reset restarts full power-on sequence
// RL25 - system path enabled 30ms after power-on
// RL26 - reserved mode codes take no pin action
`timescale 1ns/10ps
`include "power_reset_regs.svh"

module power_reset_sequencer #(
	parameter int unsigned MS_CYCLES = `MS_CYCLES,
	parameter bit SOFT_CLEARS_REGS = 1'b0
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_power_ctrl_pin_a,
	input wire logic i_power_ctrl_pin_b,
	input wire power_reset_pkg::supply_t i_supply,
	input wire logic [3:0] i_power_reset_mode_code,
	input wire power_reset_pkg::seq_sel_t [`REG_COUNT-1:0] i_seq_sel,
	input wire logic [`REG_COUNT-1:0] i_manual_en,
	input wire logic i_ldo1_always_on,
	input wire logic [2:0] i_input_limit_sel,
	input wire logic [1:0] i_input_limit_blank_sel,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_rst_n,
	output logic [`REG_COUNT-1:0] o_reg_en,
	output logic o_sys_path_en,
	output logic o_cell_switch_closed,
	output logic o_overvoltage_lockout,
	output logic o_overvoltage_lockout_irq,
	output logic [2:0] o_input_limit,
	output logic o_pin_b_out,
	output logic o_pin_b_oe
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// ----------------------------------------
	// timebase and input synchronisers
	// ----------------------------------------
	logic [15:0] presc_r;
	logic ms_tick_r;
	power_reset_pkg::supply_t sup_s1_r;
	power_reset_pkg::supply_t sup_s2_r;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			presc_r <= '0;
			ms_tick_r <= 1'b0;
		end else if (presc_r >= 16'(MS_CYCLES - 1)) begin
			presc_r <= '0;
			ms_tick_r <= 1'b1;
		end else begin
			presc_r <= presc_r + 16'd1;
			ms_tick_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sup_s1_r <= '0;
			sup_s2_r <= '0;
		end else begin
			sup_s1_r <= i_supply;
			sup_s2_r <= sup_s1_r;
		end
	end

	logic [1:0] pin_lvl;
	logic [1:0] pin_prev_r;
	power_reset_pkg::ms_t low_ms [2];
	wire [1:0] pin_raw = {i_power_ctrl_pin_b, i_power_ctrl_pin_a};

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_pin
			pin_filter u_filter (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_pin(pin_raw[gp]),
				.i_ms_tick(ms_tick_r),
				.o_level(pin_lvl[gp]),
				.o_low_ms(low_ms[gp])
			);
		end
	endgenerate

	// ----------------------------------------
	// charger validity
	// ----------------------------------------
	logic chg_valid_r;
	logic chg_valid_nxt;
	assign chg_valid_nxt = sup_s2_r.chg_det && sup_s2_r.chg_above_cell && !sup_s2_r.chg_ov; // RL21
	wire chg_insert = chg_valid_nxt && !chg_valid_r;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			chg_valid_r <= 1'b0;
			pin_prev_r <= 2'h3;
		end else begin
			chg_valid_r <= chg_valid_nxt;
			pin_prev_r <= pin_lvl;
		end
	end

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	power_reset_pkg::mode_t mode;
	assign mode = power_reset_pkg::mode_t'(i_power_reset_mode_code);
	wire [1:0] rise = pin_lvl & ~pin_prev_r;
	wire [1:0] fall = ~pin_lvl & pin_prev_r;
	wire key_short = ms_tick_r && low_ms[0] == `KEY_SHORT_MS;
	wire key_long = ms_tick_r && low_ms[0] == `KEY_LONG_S * `MS_PER_S + 14'd1;
	wire key_long_eq = ms_tick_r && low_ms[0] == `KEY_LONG_S * `MS_PER_S;
	wire key_off = ms_tick_r && low_ms[0] == `KEY_OFF_S * `MS_PER_S + 14'd1;
	wire pin_b_off = ms_tick_r && low_ms[1] == `KEY_OFF_S * `MS_PER_S + 14'd1;

	logic req_on_pin;
	logic req_off_pin;
	logic soft_now;
	logic pend_start;
	logic always_mode;
	power_reset_pkg::pend_t pend_new;
	wire lo_mode = mode == power_reset_pkg::MODE_INS_LO || mode == power_reset_pkg::MODE_ABORT_LO;

	// pin a wins when both pins start a delayed reset together
	always_comb begin
		req_on_pin = 1'b0;
		req_off_pin = 1'b0;
		soft_now = 1'b0;
		always_mode = 1'b1;
		pend_new = '0;
		pend_new.active = 1'b1;
		pend_new.ms = `SHORT_DELAY_MS;
		pend_start = 1'b0;
		case (mode)
			power_reset_pkg::MODE_ONOFF_HI, power_reset_pkg::MODE_ONOFF_LO: begin
				always_mode = 1'b0;
				req_on_pin = pin_lvl[0] ^ (mode == power_reset_pkg::MODE_ONOFF_LO); // RL1 RL2
				req_off_pin = !req_on_pin;
				soft_now = fall[1];
			end
			power_reset_pkg::MODE_EDGE_RISE, power_reset_pkg::MODE_EDGE_FALL: begin
				pend_start = (mode == power_reset_pkg::MODE_EDGE_RISE) ? |rise : |fall; // RL3 RL4
				pend_new.pin_b = (mode == power_reset_pkg::MODE_EDGE_RISE) ? !rise[0] : !fall[0];
			end
			power_reset_pkg::MODE_INS_HI, power_reset_pkg::MODE_INS_LO,
			power_reset_pkg::MODE_ABORT_HI, power_reset_pkg::MODE_ABORT_LO: begin
				pend_start = chg_insert && ((pin_lvl[0] ^ lo_mode) || (pin_lvl[1] ^ lo_mode)); // RL6 RL7 RL11 RL12
				pend_new.pin_b = !(pin_lvl[0] ^ lo_mode);
				if (mode == power_reset_pkg::MODE_ABORT_HI || mode == power_reset_pkg::MODE_ABORT_LO) begin
					pend_new.abort_en = 1'b1;
					// abort on the level opposite to the one that armed the slot
					pend_new.abort_lvl = lo_mode;
					pend_new.ms = `ABORT_DELAY_S * `MS_PER_S;
				end
			end
			power_reset_pkg::MODE_KEY_ONOFF: begin
				always_mode = 1'b0;
				req_on_pin = key_short; // RL8
				req_off_pin = key_off;
			end
			power_reset_pkg::MODE_KEY_RESET: begin
				req_on_pin = key_long; // RL9
				soft_now = key_off;
			end
			power_reset_pkg::MODE_KEY_MANUAL: begin
				req_on_pin = key_long_eq; // RL10
				soft_now = pin_b_off;
			end
			default: begin
				always_mode = 1'b0; // RL26
			end
		endcase
		pend_new.hard = !pend_new.pin_b;
	end

	// ----------------------------------------
	// delayed reset slot
	// ----------------------------------------
	power_reset_pkg::pend_t pend_r;
	wire pend_abort = pend_r.abort_en && (pin_lvl[pend_r.pin_b] == pend_r.abort_lvl);
	wire pend_due = pend_r.active && !pend_abort && pend_r.ms == 14'd0;
	wire hard_fire = pend_due && pend_r.hard;
	wire soft_fire = soft_now || (pend_due && !pend_r.hard);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			pend_r <= '0;
		end else if (pend_r.active) begin
			if (pend_abort || pend_r.ms == 14'd0) begin
				pend_r.active <= 1'b0; // RL11 RL12
			end else if (ms_tick_r) begin
				pend_r.ms <= pend_r.ms - 14'd1;
			end
		end else if (pend_start) begin
			pend_r <= pend_new;
		end
	end

	// ----------------------------------------
	// overcurrent deglitch
	// ----------------------------------------
	power_reset_pkg::ms_t oc_ms_r;
	wire oc_trip = oc_ms_r > `OC_DEGLITCH_MS;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			oc_ms_r <= '0;
		end else if (!sup_s2_r.cell_oc) begin
			oc_ms_r <= '0;
		end else if (ms_tick_r && !oc_trip) begin
			oc_ms_r <= oc_ms_r + 14'd1; // RL18
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [1:0] boot_sel_r;
	power_reset_pkg::pwr_state_t state_r;
	logic soft_active;
	wire cmd_off = i_reg_wr && i_reg_addr == `POWER_COMMAND_ADDR && i_reg_wdata[`POWER_OFF_BIT];
	wire off_req = cmd_off || oc_trip;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			boot_sel_r <= `BOOT_DELAY_RESET;
		end else if (i_reg_wr && i_reg_addr == `BOOT_DELAY_CONFIG_ADDR) begin
			boot_sel_r <= i_reg_wdata[`BOOT_DELAY_MSB:`BOOT_DELAY_LSB];
		end else if (SOFT_CLEARS_REGS && soft_fire && state_r != power_reset_pkg::ST_OFF) begin
			boot_sel_r <= `BOOT_DELAY_RESET; // RL23
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_reg_rdata <= '0;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				`BOOT_DELAY_CONFIG_ADDR: o_reg_rdata <= {6'h00, boot_sel_r};
				`SEQ_STATUS_ADDR: o_reg_rdata <= {i_power_reset_mode_code, pend_r.active, soft_active, state_r};
				default: o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// power state and sequence timer
	// ----------------------------------------
	function automatic power_reset_pkg::ms_t boot_ms(input logic [1:0] sel);
		case (sel)
			2'h0: boot_ms = `BOOT_DLY0_MS;
			2'h1: boot_ms = `BOOT_DLY1_MS;
			2'h2: boot_ms = `BOOT_DLY2_MS;
			default: boot_ms = `BOOT_DLY3_MS;
		endcase
	endfunction : boot_ms

	power_reset_pkg::ms_t seq_ms_r;
	power_reset_pkg::ms_t trst;
	assign trst = boot_ms(boot_sel_r);
	wire [13:0] point1 = `SEQ_START_MS + (trst >> 2);
	wire [13:0] point2 = `SEQ_START_MS + (trst >> 1);
	wire [13:0] release_ms = `SEQ_START_MS + trst;
	wire req_on = req_on_pin || chg_insert;

	// command and overcurrent off requests outrank everything; a hard reset restarts from zero
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r <= power_reset_pkg::ST_OFF;
			seq_ms_r <= '0;
		end else if (off_req) begin
			state_r <= power_reset_pkg::ST_OFF; // RL5 RL18
		end else if (hard_fire || (state_r == power_reset_pkg::ST_OFF && req_on)) begin
			state_r <= power_reset_pkg::ST_SEQ; // RL24
			seq_ms_r <= '0;
		end else if (state_r != power_reset_pkg::ST_OFF && req_off_pin) begin
			state_r <= power_reset_pkg::ST_OFF;
		end else if (state_r == power_reset_pkg::ST_SEQ && sup_s2_r.sys_uvlo) begin
			if (chg_valid_r) begin
				seq_ms_r <= `SYS_PATH_MS; // RL17
			end else begin
				state_r <= power_reset_pkg::ST_OFF;
			end
		end else if (state_r == power_reset_pkg::ST_SEQ && seq_ms_r >= release_ms) begin
			state_r <= power_reset_pkg::ST_ON; // RL14
		end else if (state_r == power_reset_pkg::ST_SEQ && ms_tick_r) begin
			seq_ms_r <= seq_ms_r + 14'd1;
		end
	end

	// ----------------------------------------
	// soft reset pulse and reset output
	// ----------------------------------------
	power_reset_pkg::ms_t soft_ms_r;
	assign soft_active = soft_ms_r != 14'd0;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			soft_ms_r <= '0;
		end else if (soft_fire && state_r != power_reset_pkg::ST_OFF) begin
			soft_ms_r <= `SOFT_PULSE_MS; // RL23
		end else if (soft_active && ms_tick_r) begin
			soft_ms_r <= soft_ms_r - 14'd1;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rst_n <= 1'b0;
		end else begin
			o_rst_n <= state_r == power_reset_pkg::ST_ON && !soft_active; // RL14 RL23
		end
	end

	// ----------------------------------------
	// regulator enables
	// ----------------------------------------
	genvar gr;
	generate
		for (gr = 0; gr < `REG_COUNT; gr++) begin : g_reg
			logic reached;
			logic always_on;
			always_comb begin
				case (i_seq_sel[gr])
					3'h0: reached = seq_ms_r >= `SEQ_START_MS;
					3'h1: reached = seq_ms_r >= point1;
					3'h2: reached = seq_ms_r >= point2;
					3'h3: reached = 1'b0;
					default: reached = 1'b0;
				endcase
			end
			assign always_on = (gr == `LDO1_IDX) && i_ldo1_always_on && sup_s2_r.supply_present;
			always_ff @(posedge i_clk or posedge i_reset) begin
				if (i_reset) begin
					o_reg_en[gr] <= 1'b0;
				end else if (always_on) begin
					o_reg_en[gr] <= 1'b1; // RL16
				end else if (state_r == power_reset_pkg::ST_ON) begin
					o_reg_en[gr] <= (i_seq_sel[gr] < `SEQ_DEFAULT_OFF) || i_manual_en[gr]; // RL15
				end else if (state_r == power_reset_pkg::ST_SEQ) begin
					o_reg_en[gr] <= reached; // RL13
				end else begin
					o_reg_en[gr] <= 1'b0;
				end
			end
			AST_DEFAULT_OFF: assert property ( // RL15
				(i_seq_sel[gr] >= `SEQ_DEFAULT_OFF && state_r != power_reset_pkg::ST_ON && !always_on)
				|=> !o_reg_en[gr])
				else $error("default-off regulator enabled before release");
		end
	endgenerate

	// ----------------------------------------
	// power path, lockout and input limit
	// ----------------------------------------
	wire path_nxt = state_r == power_reset_pkg::ST_ON ||
		(state_r == power_reset_pkg::ST_SEQ && seq_ms_r >= `SYS_PATH_MS);
	power_reset_pkg::ms_t blank_ms_r;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_sys_path_en <= 1'b0;
			o_cell_switch_closed <= 1'b0;
			o_overvoltage_lockout <= 1'b0;
			o_overvoltage_lockout_irq <= 1'b0;
		end else begin
			o_sys_path_en <= path_nxt; // RL25
			o_cell_switch_closed <= (path_nxt || sup_s2_r.chg_ov) && !chg_valid_nxt; // RL19 RL21
			o_overvoltage_lockout <= sup_s2_r.chg_ov; // RL20
			o_overvoltage_lockout_irq <= sup_s2_r.chg_ov;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			blank_ms_r <= '0;
		end else if (chg_insert) begin
			case (i_input_limit_blank_sel)
				2'h1: blank_ms_r <= `BLANK1_MS;
				2'h2: blank_ms_r <= `BLANK2_MS;
				2'h3: blank_ms_r <= `BLANK3_MS;
				default: blank_ms_r <= '0;
			endcase
		end else if (blank_ms_r != 14'd0 && ms_tick_r) begin
			blank_ms_r <= blank_ms_r - 14'd1;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_input_limit <= '0;
		end else begin
			o_input_limit <= (blank_ms_r != 14'd0) ? `ILIM_MAX : i_input_limit_sel; // RL22
		end
	end

	// open-drain echo pulls low while the key is held, in the key on/off and key reset modes only
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_pin_b_out <= 1'b0;
			o_pin_b_oe <= 1'b0;
		end else begin
			o_pin_b_out <= 1'b0;
			o_pin_b_oe <= !pin_lvl[0] && (mode == power_reset_pkg::MODE_KEY_ONOFF ||
				mode == power_reset_pkg::MODE_KEY_RESET); // RL8 RL9
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_on_always;
		state_r == power_reset_pkg::ST_ON && always_mode;
	endsequence
	sequence s_went_off;
		state_r == power_reset_pkg::ST_OFF;
	endsequence

	AST_ALWAYS_OFF_CMD: assert property (s_on_always ##1 s_went_off |-> $past(off_req)) // RL5
		else $error("always-on mode left on state without command");
	AST_RESERVED_NO_PEND: assert property ((i_power_reset_mode_code > 4'ha) |-> !pend_start && !soft_now) // RL26
		else $error("reserved mode started a pin action");
	AST_OC_OFF: assert property (oc_trip |=> state_r == power_reset_pkg::ST_OFF) // RL18
		else $error("overcurrent did not power off");
	AST_SEQ_RST_LOW: assert property (state_r == power_reset_pkg::ST_SEQ |=> !o_rst_n) // RL14
		else $error("reset released during sequencing");
	AST_SOFT_PULSE: assert property ($rose(soft_active) |=> !o_rst_n [*3]) // RL23
		else $error("soft reset pulse missing");
	AST_CELL_SWITCH: assert property (chg_valid_nxt |=> !o_cell_switch_closed) // RL19
		else $error("cell switch closed with valid charger");
	AST_OVERVOLTAGE_LOCKOUT: assert property (sup_s2_r.chg_ov |=> o_overvoltage_lockout && o_overvoltage_lockout_irq && o_cell_switch_closed) // RL20
		else $error("overvoltage lockout not taken");
	AST_ILIM_BLANK: assert property (blank_ms_r != 14'd0 |=> o_input_limit == `ILIM_MAX) // RL22
		else $error("input limit not raised during blanking");
	AST_HARD_RESTART: assert property (hard_fire && !off_req |=> state_r == power_reset_pkg::ST_SEQ
		&& seq_ms_r == 14'd0 ##1 !o_rst_n) // RL24
		else $error("hard reset did not restart sequence");
endmodule : power_reset_sequencer

// ### test/key_partner.sv
// push-button and host line model on both control pins
`timescale 1ns/10ps

module key_partner (
	input wire logic i_press_a,
	input wire logic i_level_b,
	input wire logic i_pin_b_out,
	input wire logic i_pin_b_oe,
	output logic o_pin_a,
	output logic o_pin_b
);
	assign o_pin_a = i_press_a;
	// pin b is pulled up, so the line follows the host unless the echo pulls it
	assign o_pin_b = i_pin_b_oe ? i_pin_b_out : i_level_b;
endmodule : key_partner

// ### test/power_reset_sequencer_tb.sv
// self-checking testbench of the power/reset sequencer
`timescale 1ns/10ps
`include "power_reset_regs.svh"

module power_reset_sequencer_tb;
	localparam int MSC = 10;
	logic i_clk = 0;
	logic i_reset = 1;
	logic a = 1;
	logic b = 1;
	logic wr = 0;
	logic rd = 0;
	logic ao = 0;
	logic pa, pb, rst_n, path, sw, overvoltage_lockout, irq, b_out, b_oe;
	power_reset_pkg::supply_t sup = 6'h01;
	power_reset_pkg::seq_sel_t [`REG_COUNT-1:0] ssel = '0;
	logic [3:0] mode = 4'hb;
	logic [2:0] lsel = 3'h0;
	logic [2:0] lim;
	logic [1:0] blk = 2'h0;
	logic [1:0] bsel;
	logic [7:0] addr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] rdat, v;
	logic [`REG_COUNT-1:0] en, xen;
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;

	key_partner part (.i_press_a(a), .i_level_b(b), .i_pin_b_out(b_out), .i_pin_b_oe(b_oe),
		.o_pin_a(pa), .o_pin_b(pb));
	power_reset_sequencer #(.MS_CYCLES(MSC)) uut (.i_clk(i_clk), .i_reset(i_reset),
		.i_power_ctrl_pin_a(pa), .i_power_ctrl_pin_b(pb), .i_supply(sup),
		.i_power_reset_mode_code(mode), .i_seq_sel(ssel), .i_manual_en('0),
		.i_ldo1_always_on(ao), .i_input_limit_sel(lsel), .i_input_limit_blank_sel(blk),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat),
		.o_rst_n(rst_n), .o_reg_en(en), .o_sys_path_en(path), .o_cell_switch_closed(sw),
		.o_overvoltage_lockout(overvoltage_lockout), .o_overvoltage_lockout_irq(irq), .o_input_limit(lim),
		.o_pin_b_out(b_out), .o_pin_b_oe(b_oe));

	function automatic int trst(logic [1:0] s);
		return s == 2'h0 ? 80 : s == 2'h1 ? 180 : s == 2'h2 ? 300 : 420;
	endfunction : trst

	function automatic logic pick(int k);
		return k == 0 ? rst_n : path;
	endfunction : pick

	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (e !== g) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic rng(string s, int lo, int hi);
		comparisons++;
		if (n < lo || n > hi) begin
			bad_count++;
			$display("wrong value %s expected %0d..%0d seen %0d", s, lo, hi, n);
		end
	endtask : rng

	task automatic ms(int k);
		repeat (k * MSC) @(negedge i_clk);
	endtask : ms

	// bounded wait on rst_n (0) or the system path (1)
	task automatic wait_sig(int k, logic val, int lim_c);
		n = 0;
		while (pick(k) !== val && n < lim_c) begin
			@(negedge i_clk);
			n++;
		end
	endtask : wait_sig

	task automatic reg_wr(logic [7:0] ad, logic [7:0] d);
		@(negedge i_clk);
		addr = ad;
		wd = d;
		wr = 1;
		@(negedge i_clk);
		wr = 0;
	endtask : reg_wr

	task automatic reg_rd(logic [7:0] ad);
		@(negedge i_clk);
		addr = ad;
		rd = 1;
		@(negedge i_clk);
		rd = 0;
		v = rdat;
	endtask : reg_rd

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		forever #10 i_clk = ~i_clk;
	end

	// a hang beyond the planned run counts as a mismatch
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	initial begin
		v = 8'($urandom(32'hc036));
		lsel = 3'($urandom);
		ssel = 27'($urandom);
		for (int i = 0; i < `REG_COUNT; i++) begin
			xen[i] = ssel[i] < 3'h4;
		end
		repeat (5) @(negedge i_clk);
		i_reset = 0;
		@(negedge i_clk);
		chk("rst_n", 0, rst_n);
		a = 0;
		ms(15);
		a = 1;
		ms(15);
		chk("reserved path", 0, path);
		reg_rd(8'h4d);
		chk("boot reset", 0, v);
		reg_rd(8'h60);
		chk("unmapped", 0, v);
		v = 8'($urandom);
		bsel = v[1:0];
		reg_wr(8'h4d, v);
		reg_rd(8'h4d);
		chk("boot sel", {6'h0, bsel}, v);
		mode = 4'h0;
		wait_sig(1, 1, 1000);
		rng("path ms", 290, 320);
		chk("rst at path", 0, rst_n);
		wait_sig(0, 1, 6000);
		rng("boot ms", (15 + trst(bsel)) * MSC - 30, (15 + trst(bsel)) * MSC + 30);
		ms(2);
		chk("reg en", xen, en);
		chk("switch", 1, sw);
		a = 0;
		ms(15);
		chk("pin off", 0, path);
		a = 1;
		wait_sig(0, 1, 8000);
		b = 0;
		wait_sig(0, 0, 400);
		rng("soft start", 90, 130);
		wait_sig(0, 1, 400);
		rng("soft width", 85, 105);
		b = 1;
		ms(15);
		mode = 4'h2;
		a = 0;
		ms(20);
		a = 1;
		wait_sig(0, 0, 3000);
		rng("hard delay", 2070, 2140);
		wait_sig(0, 1, 6000);
		rng("hard seq", (45 + trst(bsel)) * MSC - 30, (45 + trst(bsel)) * MSC + 30);
		a = 0;
		ms(250);
		chk("always on", 1, rst_n);
		reg_wr(8'h4e, 8'h01);
		reg_rd(8'h4f);
		chk("state off", 0, {v[1:0], path});
		ao = 1;
		ms(1);
		chk("ldo1 always on", 1, en[`LDO1_IDX]);
		ao = 0;
		mode = 4'h6;
		a = 1;
		ms(15);
		a = 0;
		ms(20);
		chk("key echo", 2'h2, {b_oe, pb});
		wait_sig(1, 1, 5000);
		rng("key on", 4170, 4240);
		a = 1;
		ms(15);
		chk("echo off", 2'h1, {b_oe, pb});
		reg_wr(8'h4e, 8'h01);
		ms(1);
		chk("cmd off", 0, path);
		mode = 4'hb;
		blk = 2'h3;
		sup.chg_det = 1;
		sup.chg_above_cell = 1;
		ms(3);
		chk("blank limit", 3'h7, lim);
		wait_sig(1, 1, 1000);
		ms(2);
		chk("limit", lsel, lim);
		chk("switch open", 0, sw);
		sup.chg_above_cell = 0;
		ms(1);
		chk("switch invalid", 1, sw);
		mode = 4'h9;
		sup.chg_above_cell = 1;
		ms(1);
		reg_rd(8'h4f);
		chk("pending", 1, v[3]);
		a = 0;
		ms(15);
		reg_rd(8'h4f);
		chk("aborted", 0, v[3]);
		sup.chg_ov = 1;
		ms(1);
		chk("lockout", 3'h7, {overvoltage_lockout, irq, sw});
		tally_and_finish();
	end
endmodule : power_reset_sequencer_tb
